/* hdl/sfod_pkg.sv */
// Constants and types shared by the sync filter / over-range block.
// Assumes one core clock at 100 MHz that also serves as link and sample clock.
package sfod_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 4;
  localparam int SAMPLE_W = 9;
  localparam int HOLD_W = 10;
  localparam int INIT_W = 10;

  // Serial port frame
  localparam logic [4:0] SPI_ADDR_BITS = 5'h10;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

  // Register offsets
  localparam logic [ADDR_W-1:0] RESYNC_FILTER_ADDR = 15'h0210;
  localparam logic [ADDR_W-1:0] OVR_LEVEL_ADDR = 15'h0211;
  localparam logic [ADDR_W-1:0] OVERRANGE_OUTPUT_CONFIG_ADDR = 15'h0213;
  localparam logic [ADDR_W-1:0] STARTUP_ADDR = 15'h0270;

  // Reset values
  localparam logic [DATA_W-1:0] RESYNC_FILTER_RST = 8'h03;
  localparam logic [DATA_W-1:0] OVR_LEVEL_RST = 8'hF2;
  localparam logic [DATA_W-1:0] OVERRANGE_OUTPUT_CONFIG_RST = 8'h07;

  // Field positions
  localparam int THRESH_MSB = 4;
  localparam int OVERRANGE_OUT_ENABLE_BIT = 3;
  localparam int STRETCH_MSB = 2;

  // Minimum hold base, in sample cycles
  localparam logic [HOLD_W-1:0] HOLD_BASE = 10'h004;

  // Start-up sequence length
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_TIME_NS = 10000;
  localparam logic [INIT_W-1:0] INIT_CYCLES = INIT_W'(INIT_TIME_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SYNC_HIGH = 2'h0,
    SYNC_LOW_RUN = 2'h1,
    SYNC_REQUEST = 2'h3
  } sfod_sync_state_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'h0,
    SPI_ADDR = 2'h1,
    SPI_DATA = 2'h3
  } sfod_spi_state_t;

endpackage

/* hdl/sfod_spi_slave.sv */
// Serial register port: 24-bit frames, read flag, 15-bit address, 8 data bits.
// Assumes the serial clock runs at most one eighth of core_clk.
`timescale 1ns/10ps
module sfod_spi_slave
  import sfod_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Register access
  output logic [sfod_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic [sfod_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [sfod_pkg::DATA_W-1:0] reg_rdata
);
  import sfod_pkg::*;

  typedef struct packed {
    logic [2:0] sclk_pipe;
    logic [1:0] cs_pipe;
    logic [1:0] sdi_pipe;
    sfod_spi_state_t state;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic is_read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] shift_out;
    logic out_loaded;
    logic sdo;
    logic sdo_oe;
    logic wr;
  } sfod_spi_st_t;

  sfod_spi_st_t st_reg;
  sfod_spi_st_t st_next;
  logic rise;
  logic fall;
  logic cs_act;

  always_comb begin
    st_next = st_reg;
    st_next.sclk_pipe = {st_reg.sclk_pipe[1:0], spi_sclk};
    st_next.cs_pipe = {st_reg.cs_pipe[0], spi_cs_n};
    st_next.sdi_pipe = {st_reg.sdi_pipe[0], spi_sdi};
    st_next.wr = 1'b0;
    rise = st_reg.sclk_pipe[1] & ~st_reg.sclk_pipe[2];
    fall = ~st_reg.sclk_pipe[1] & st_reg.sclk_pipe[2];
    cs_act = ~st_reg.cs_pipe[1];
    if (!cs_act) begin
      st_next.state = SPI_IDLE;
      st_next.bit_cnt = 5'h00;
      st_next.out_loaded = 1'b0;
      st_next.sdo_oe = 1'b0;
    end else begin
      if (st_reg.state == SPI_IDLE) begin
        st_next.state = SPI_ADDR;
      end
      if (rise && st_reg.bit_cnt != SPI_FRAME_BITS) begin
        st_next.shift_in = {st_reg.shift_in[14:0], st_reg.sdi_pipe[1]};
        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
        if (st_reg.bit_cnt == SPI_ADDR_BITS - 5'h01) begin
          st_next.state = SPI_DATA;
          st_next.is_read = st_reg.shift_in[14];
          st_next.addr = {st_reg.shift_in[13:0], st_reg.sdi_pipe[1]};
        end
        if (st_reg.bit_cnt == SPI_FRAME_BITS - 5'h01 && !st_reg.is_read) begin
          st_next.wr = 1'b1;
        end
      end
      if (fall && st_reg.state == SPI_DATA && st_reg.is_read) begin
        if (!st_reg.out_loaded) begin
          st_next.shift_out = reg_rdata;
          st_next.sdo = reg_rdata[DATA_W-1];
          st_next.out_loaded = 1'b1;
          st_next.sdo_oe = 1'b1;
        end else begin
          st_next.shift_out = {st_reg.shift_out[DATA_W-2:0], 1'b0};
          st_next.sdo = st_reg.shift_out[DATA_W-2];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      // Select idles high, so no false frame start after reset
      st_reg.cs_pipe <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  assign spi_sdo = st_reg.sdo;
  assign spi_sdo_oe = st_reg.sdo_oe;
  assign reg_addr = st_reg.addr;
  assign reg_wr = st_reg.wr;
  assign reg_wdata = st_reg.shift_in[DATA_W-1:0];

endmodule

/* hdl/sfod_overrange_chan.sv */
// One over-range channel: magnitude compare and stretched flag output.
// Assumes one sample per core_clk, two's complement, from the same clock.
`timescale 1ns/10ps
module sfod_overrange_chan
  import sfod_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sample and settings
  input wire logic [sfod_pkg::SAMPLE_W-1:0] sample,
  input wire logic [sfod_pkg::DATA_W-1:0] level,
  input wire logic out_enable,
  input wire logic [2:0] stretch_exp,
  // Flag
  output logic flag
);
  import sfod_pkg::*;

  typedef struct packed {
    logic [HOLD_W-1:0] hold_cnt;
    logic flag;
  } sfod_chan_st_t;

  sfod_chan_st_t st_reg;
  sfod_chan_st_t st_next;
  logic [SAMPLE_W-1:0] mag;
  logic hit;
  logic [HOLD_W-1:0] hold_len;

  always_comb begin
    st_next = st_reg;
    mag = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
    hit = mag >= {1'b0, level};
    hold_len = HOLD_BASE << stretch_exp;
    if (hit) begin
      st_next.hold_cnt = hold_len - 10'h001;
      st_next.flag = 1'b1;
    end else if (st_reg.hold_cnt != 10'h000) begin
      st_next.hold_cnt = st_reg.hold_cnt - 10'h001;
      st_next.flag = 1'b1;
    end else begin
      st_next.flag = 1'b0;
    end
    st_next.flag = st_next.flag & out_enable;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag = st_reg.flag;

  hit_raises_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    hit && out_enable |=> flag)
    else $error("over-range hit did not raise flag");

  disabled_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !out_enable |=> !flag)
    else $error("flag high while output disabled");

  hold_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    hit |=> st_reg.hold_cnt == ((HOLD_BASE << $past(stretch_exp)) - 10'h001))
    else $error("hold counter not loaded with stretch length");

  hold_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.hold_cnt != 10'h000 && out_enable |=> flag)
    else $error("flag dropped during hold");

  hold_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    hit && st_reg.hold_cnt != 10'h000 && $stable(stretch_exp)
    |=> st_reg.hold_cnt == (HOLD_BASE << $past(stretch_exp)) - 10'h001)
    else $error("new hit did not restart hold");

endmodule

/* hdl/sfod_top.sv */
// Resync request filter, four over-range channels and start-up status.
// Assumes core_clk is the link clock and sample clock; pins are asynchronous.
`timescale 1ns/10ps
module sfod_top
  import sfod_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Serial register port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Link request line and link control
  input wire logic resync_n,
  input wire logic serial_link_enable,
  output logic resync_request,
  output logic error_report,
  // Samples
  input wire logic [sfod_pkg::SAMPLE_W-1:0] sample_a,
  input wire logic [sfod_pkg::SAMPLE_W-1:0] sample_b,
  input wire logic [sfod_pkg::SAMPLE_W-1:0] sample_c,
  input wire logic [sfod_pkg::SAMPLE_W-1:0] sample_d,
  // Over-range flags
  output logic overrange_flag_a,
  output logic overrange_flag_b,
  output logic overrange_flag_c,
  output logic overrange_flag_d,
  // Start-up status
  output logic init_done
);
  import sfod_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [DATA_W-1:0] resync_filter;
    logic [DATA_W-1:0] ovr_level;
    logic [DATA_W-1:0] overrange_output_config;
    logic [1:0] sync_pipe;
    logic [1:0] link_en_pipe;
    sfod_sync_state_t sync_state;
    logic [THRESH_MSB:0] run_cnt;
    logic resync_request;
    logic error_report;
    logic [INIT_W-1:0] init_cnt;
    logic init_done;
  } sfod_top_st_t;

  sfod_top_st_t st_reg;
  sfod_top_st_t st_next;

  logic [ADDR_W-1:0] reg_addr;
  logic reg_wr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic sync_low;
  logic link_on;
  logic [THRESH_MSB:0] thresh;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] samples;
  logic [NUM_CH-1:0] flags;

  assign sync_low = ~st_reg.sync_pipe[1];
  assign link_on = st_reg.link_en_pipe[1];
  assign thresh = st_reg.resync_filter[THRESH_MSB:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  sfod_spi_slave u_spi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  always_comb begin
    unique case (reg_addr)
      RESYNC_FILTER_ADDR: reg_rdata = st_reg.resync_filter;
      OVR_LEVEL_ADDR: reg_rdata = st_reg.ovr_level;
      OVERRANGE_OUTPUT_CONFIG_ADDR: reg_rdata = st_reg.overrange_output_config;
      STARTUP_ADDR: reg_rdata = {7'h00, st_reg.init_done};
      default: reg_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;
    st_next.resync_request = 1'b0;
    st_next.error_report = 1'b0;
    st_next.sync_pipe = {st_reg.sync_pipe[0], resync_n};
    st_next.link_en_pipe = {st_reg.link_en_pipe[0], serial_link_enable};

    if (reg_wr) begin
      unique case (reg_addr)
        RESYNC_FILTER_ADDR: st_next.resync_filter = reg_wdata;
        OVR_LEVEL_ADDR: st_next.ovr_level = reg_wdata;
        OVERRANGE_OUTPUT_CONFIG_ADDR: st_next.overrange_output_config = reg_wdata;
        default: st_next.overrange_output_config = st_reg.overrange_output_config;
      endcase
    end

    if (!st_reg.init_done) begin
      if (st_reg.init_cnt == INIT_CYCLES - 10'h001) begin
        st_next.init_done = 1'b1;
      end else begin
        st_next.init_cnt = st_reg.init_cnt + 10'h001;
      end
    end

    if (!link_on) begin
      st_next.sync_state = SYNC_HIGH;
      st_next.run_cnt = '0;
    end else begin
      unique case (st_reg.sync_state)
        SYNC_HIGH: begin
          st_next.run_cnt = '0;
          if (sync_low) begin
            if (thresh == '0) begin
              st_next.resync_request = 1'b1;
              st_next.sync_state = SYNC_REQUEST;
            end else begin
              st_next.run_cnt = 5'h01;
              st_next.sync_state = SYNC_LOW_RUN;
            end
          end
        end
        SYNC_LOW_RUN: begin
          if (sync_low) begin
            if (st_reg.run_cnt >= thresh) begin
              st_next.resync_request = 1'b1;
              st_next.sync_state = SYNC_REQUEST;
            end else begin
              st_next.run_cnt = st_reg.run_cnt + 5'h01;
            end
          end else begin
            st_next.error_report = 1'b1;
            st_next.run_cnt = '0;
            st_next.sync_state = SYNC_HIGH;
          end
        end
        SYNC_REQUEST: begin
          if (!sync_low) begin
            st_next.run_cnt = '0;
            st_next.sync_state = SYNC_HIGH;
          end
        end
        default: begin
          st_next.run_cnt = '0;
          st_next.sync_state = SYNC_HIGH;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.resync_filter <= RESYNC_FILTER_RST;
      st_reg.ovr_level <= OVR_LEVEL_RST;
      st_reg.overrange_output_config <= OVERRANGE_OUTPUT_CONFIG_RST;
      st_reg.sync_pipe <= 2'h3;
      st_reg.sync_state <= SYNC_HIGH;
    end else begin
      st_reg <= st_next;
    end
  end

  assign resync_request = st_reg.resync_request;
  assign error_report = st_reg.error_report;
  assign init_done = st_reg.init_done;

  ////////////////////////////////////////////////////////////////////////////
  // Over-range channels

  assign samples = {sample_d, sample_c, sample_b, sample_a};

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    sfod_overrange_chan u_chan (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sample(samples[ch]),
      .level(st_reg.ovr_level),
      .out_enable(st_reg.overrange_output_config[OVERRANGE_OUT_ENABLE_BIT]),
      .stretch_exp(st_reg.overrange_output_config[STRETCH_MSB:0]),
      .flag(flags[ch])
    );
  end

  assign overrange_flag_a = flags[0];
  assign overrange_flag_b = flags[1];
  assign overrange_flag_c = flags[2];
  assign overrange_flag_d = flags[3];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  request_run_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    resync_request |-> $past(sync_low) && $past(st_reg.run_cnt) == $past(thresh))
    else $error("request without full low run");

  run_counts_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    link_on && st_reg.sync_state == SYNC_LOW_RUN && sync_low && st_reg.run_cnt < thresh
    |=> st_reg.run_cnt == $past(st_reg.run_cnt) + 5'h01)
    else $error("low sample not counted");

  short_run_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    error_report |-> !resync_request && $past(st_reg.sync_state) == SYNC_LOW_RUN
    && !$past(sync_low))
    else $error("error report without short run");

  one_request_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    resync_request |=> !resync_request)
    else $error("repeated request in one run");

  init_timing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(init_done) |-> $past(st_reg.init_cnt) == INIT_CYCLES - 10'h001)
    else $error("start-up done at wrong time");

  init_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    init_done |=> init_done)
    else $error("start-up status fell");

endmodule

/* verification/sfod_sync_rx_model.sv */
// Link receiver model: drives the resync request line low for a commanded run.
// Assumes runs are commanded one at a time, each launched by a one-cycle start.
`timescale 1ns/10ps
module sfod_sync_rx_model (
  // Clock
  core_clk,
  // Command
  start,
  low_len,
  // Request line
  resync_n
);
  input wire logic core_clk;
  input wire logic start;
  input wire logic [7:0] low_len;
  output logic resync_n;

  logic [7:0] run_reg = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // low runs only on command
  always @(posedge core_clk) begin
    if (start && run_reg == 8'h00) begin
      run_reg <= low_len;
    end else if (run_reg != 8'h00) begin
      run_reg <= run_reg - 8'h01;
    end
  end

  // Line idles high between requests
  assign resync_n = (run_reg == 8'h00);
endmodule

/* verification/tb_sync_filter_overrange_detect.sv */
// Self-checking bench: serial register port tasks, resync filter and over-range runs.
// Assumes the link receiver model on the request line and one 100 MHz clock.
`timescale 1ns/10ps
module tb_sync_filter_overrange_detect;
  import sfod_pkg::*;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic spi_sclk = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sdi = 1'b0;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic serial_link_enable = 1'b0;
  logic resync_n;
  logic resync_request;
  logic error_report;
  logic start = 1'b0;
  logic [7:0] low_len = 8'h00;
  logic [SAMPLE_W-1:0] samp [NUM_CH] = '{default: '0};
  logic [NUM_CH-1:0] flags;
  logic init_done;
  int miscompares = 0;
  int n_compared = 0;
  int n_req = 0;
  int n_err = 0;
  int fl_cnt [NUM_CH] = '{default: 0};
  logic [7:0] d;
  int i;

  always #5 core_clk = ~core_clk;

  sfod_top uut (
    .core_clk(core_clk), .arst_n(arst_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .resync_n(resync_n), .serial_link_enable(serial_link_enable),
    .resync_request(resync_request), .error_report(error_report),
    .sample_a(samp[0]), .sample_b(samp[1]), .sample_c(samp[2]), .sample_d(samp[3]),
    .overrange_flag_a(flags[0]), .overrange_flag_b(flags[1]),
    .overrange_flag_c(flags[2]), .overrange_flag_d(flags[3]),
    .init_done(init_done)
  );

  sfod_sync_rx_model rx (
    .core_clk(core_clk), .start(start), .low_len(low_len), .resync_n(resync_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output pulse and flag counters, sampled mid-cycle
  always @(negedge core_clk) begin
    if (resync_request === 1'b1) n_req++;
    if (error_report === 1'b1) n_err++;
    for (int k = 0; k < NUM_CH; k++) begin
      if (flags[k] === 1'b1) fl_cnt[k]++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Serial register frame: read flag, 15-bit address, 8 data bits
  task automatic spi_xfer(input logic rd, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdv);
    logic [23:0] fr;
    fr = {rd, a, wd};
    rdv = '0;
    spi_cs_n <= 1'b0;
    for (int b = 23; b >= 0; b--) begin
      spi_sdi <= fr[b];
      spi_sclk <= 1'b0;
      repeat (5) @(posedge core_clk);
      if (b < 8) rdv[b] = spi_sdo;
      if (b == 0) chk(spi_sdo_oe, rd);
      spi_sclk <= 1'b1;
      repeat (5) @(posedge core_clk);
    end
    spi_sclk <= 1'b0;
    repeat (6) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(spi_sdo_oe, 1'b0);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] r;
    spi_xfer(1'b1, a, 8'h00, r);
    chk(r, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One low run on the request line under a given threshold
  task automatic sync_case(input logic [4:0] th, input logic [7:0] len, input logic en);
    int r0;
    int e0;
    serial_link_enable <= 1'b0;
    // threshold written with link off, reserved bits zero
    spi_xfer(1'b0, RESYNC_FILTER_ADDR, {3'h0, th}, d);
    serial_link_enable <= en;
    repeat (6) @(posedge core_clk);
    r0 = n_req;
    e0 = n_err;
    low_len <= len;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (len + 12) @(posedge core_clk);
    chk(n_req - r0, (en && len > th) ? 1 : 0);
    chk(n_err - e0, (en && len <= th) ? 1 : 0);
  endtask

  // One or two hits on a channel; total flag-high cycles compared
  task automatic or_case(input int ch, input logic [SAMPLE_W-1:0] v, input int gap,
                         input int exp);
    int c0;
    c0 = fl_cnt[ch];
    samp[ch] <= v;
    @(posedge core_clk);
    samp[ch] <= '0;
    if (gap > 0) begin
      repeat (gap - 1) @(posedge core_clk);
      samp[ch] <= v;
      @(posedge core_clk);
      samp[ch] <= '0;
    end
    repeat (600) @(posedge core_clk);
    chk(fl_cnt[ch] - c0, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk(init_done, 1'b0);
    i = 0;
    while (init_done !== 1'b1 && i < 2000) begin
      @(posedge core_clk);
      i++;
    end
    if (init_done !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    rd_chk(STARTUP_ADDR, 8'h01);
    rd_chk(RESYNC_FILTER_ADDR, 8'h03);
    rd_chk(OVR_LEVEL_ADDR, 8'hF2);
    rd_chk(OVERRANGE_OUTPUT_CONFIG_ADDR, 8'h07);
    rd_chk(15'h0212, 8'h00);
    spi_xfer(1'b0, STARTUP_ADDR, 8'hFF, d);
    rd_chk(STARTUP_ADDR, 8'h01);
    sync_case(5'h03, 8'h03, 1'b1);
    sync_case(5'h03, 8'h04, 1'b1);
    sync_case(5'h03, 8'h09, 1'b1);
    sync_case(5'h00, 8'h01, 1'b1);
    sync_case(5'h1F, 8'h1F, 1'b1);
    sync_case(5'h1F, 8'h20, 1'b1);
    sync_case(5'h03, 8'h0A, 1'b0);
    rd_chk(RESYNC_FILTER_ADDR, 8'h03);
    spi_xfer(1'b0, OVR_LEVEL_ADDR, 8'h80, d);
    for (int n = 0; n < 8; n++) begin
      if (n < 4 || n == 7) begin
        spi_xfer(1'b0, OVERRANGE_OUTPUT_CONFIG_ADDR, 8'h08 | n[7:0], d);
        or_case(n % 4, 9'h080, 0, 4 << n);
      end
    end
    spi_xfer(1'b0, OVERRANGE_OUTPUT_CONFIG_ADDR, 8'h08, d);
    or_case(0, 9'h07F, 0, 0);
    or_case(1, 9'h180, 0, 4);
    or_case(2, 9'h181, 0, 0);
    or_case(3, 9'h100, 0, 4);
    or_case(0, 9'h080, 3, 7);
    spi_xfer(1'b0, OVR_LEVEL_ADDR, 8'hF2, d);
    or_case(1, 9'h0F2, 0, 4);
    or_case(2, 9'h0F1, 0, 0);
    spi_xfer(1'b0, OVERRANGE_OUTPUT_CONFIG_ADDR, 8'h00, d);
    or_case(3, 9'h0FF, 0, 0);
    end_sim();
  end
endmodule
